// ---- tag_frame_regs.svh ----
`ifndef TAG_FRAME_REGS_SVH
`define TAG_FRAME_REGS_SVH

`define CLK_HZ            200000000
`define RATE_LO_BPS       212000
`define RATE_HI_BPS       424000
`define HALF_BIT_LO       (`CLK_HZ / (2 * `RATE_LO_BPS))
`define HALF_BIT_HI       (`CLK_HZ / (2 * `RATE_HI_BPS))

`define MEM_BYTES         512
`define BLOCK_BYTES       16
`define SYS_BLOCK         5'h1e
`define SYS_PARAM_COUNT   12
`define IDX_IDM           4'h2
`define IDX_RT_READ       4'hA
`define IDX_RT_WRITE      4'hB

`define DEF_SC_HI         8'haa
`define DEF_SC_LO         8'hff
`define DEF_IDM_0         8'h02
`define DEF_IDM_1         8'hfe
`define DEF_IDM_REST      8'h00
`define DEF_RT_PARAM      8'hff

`define PREAMBLE_BYTES    5'h06
`define SYNC_CODE         16'hb24d
`define CRC_INIT          16'h0000
`define CRC_POLY          16'h1021
`define SC_WILDCARD       16'hffff
`define SC_UPPER_WILD     16'haaff
`define SC_UPPER_BYTE     8'haa
`define RTD_FIXED_HI      8'hff
`define RTD_FIXED_LO      8'h00
`define CMD_POLL          8'h00
`define RSP_POLL          8'h01
`define RSP_LEN           8'h12
`define TX_LAST_IDX       5'h1b
`define POLL_MIN_DATA     8'h03

`define REG_CTRL          10'h200
`define REG_STATUS        10'h201
`define REG_OK_COUNT      10'h202
`define REG_ERR_COUNT     10'h203
`define CTRL_RESET        8'h02

`endif

// ---- tag_frame_pkg.sv ----
`default_nettype none
package tag_frame_pkg;

  typedef logic [7:0] data_byte_type;
  typedef logic [8:0] mem_addr_type;
  typedef logic [9:0] bus_addr_type;

  typedef enum logic [3:0] {
    R_HUNT = 4'b0001,
    R_LEN  = 4'b0010,
    R_DATA = 4'b0100,
    R_CRC  = 4'b1000
  } rx_state_type;

  typedef enum logic [1:0] {
    T_IDLE = 2'b01,
    T_SEND = 2'b10
  } tx_state_type;

endpackage : tag_frame_pkg

`default_nettype wire

// ---- tag_frame_mem.sv ----
`timescale 1ns/1ps
`default_nettype none

module tag_frame_mem (
  input  wire logic                         i_ref_clk,
  input  wire logic                         i_wr,
  input  wire logic                         i_rd,
  input  wire tag_frame_pkg::mem_addr_type  i_addr,
  input  wire tag_frame_pkg::data_byte_type i_wdata,
  output tag_frame_pkg::data_byte_type      o_rdata
);
  import tag_frame_pkg::*;

  data_byte_type store [512];

  // No reset: contents model non-volatile cells, the read register is loaded on demand.
  always_ff @(posedge i_ref_clk) begin
    if (i_wr) begin
      store[i_addr] <= i_wdata;
    end
    if (i_rd) begin
      o_rdata <= store[i_addr];
    end
  end

endmodule : tag_frame_mem

`default_nettype wire

// ---- contactless_tag_frame_handler.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "tag_frame_regs.svh"

//Behaviour
//- Physical byte addresses map one to one; block k byte j sits at 16k+j.
//- Reader sends a command first; device answers with at most one response.
//- Characters are 8 bits, MSB first, no start, parity, stop or gaps.
//- Manchester bits at 212 or 424 kbps; device answers by load modulation.
//- Frame: six zero bytes, sync code, length, data field, two CRC bytes.
//- Length byte is data bytes plus one and marks the end of data.
//- CRC-16 with zero start value and polynomial x16+x12+x5+1.
//- Poll with wildcard code FFFF is answered whatever code is stored.
//- Poll with AAFF is answered when stored upper code byte is AA.
//- Any other poll code is answered only on an exact match.
//- The compared code comes from the system code bytes of memory.
//- Poll answer carries the 8-byte card identifier from the system area.
//- Poll answer carries an 8-byte response time descriptor.
//- Descriptor bytes 0, 1, 7 are FF and bytes 2 to 4 are 00.
//- Descriptor bytes 5 and 6 are the stored read and write parameters.
//- Without a valid system area the code defaults to AA then FF.
//- Time parameters default to FF and are taken only once after each reset.
module contactless_tag_frame_handler (
  input  wire logic                         i_ref_clk,
  input  wire logic                         i_rst_b,
  input  wire tag_frame_pkg::bus_addr_type  i_addr,
  input  wire tag_frame_pkg::data_byte_type i_wr_data,
  input  wire logic                         i_wr,
  input  wire logic                         i_rd,
  output tag_frame_pkg::data_byte_type      o_rd_data,
  input  wire logic                         i_sys_area_valid,
  input  wire logic                         i_rx_bit,
  input  wire logic                         i_rx_bit_stb,
  output logic                              o_load_mod,
  output logic                              o_tx_active
);
  import tag_frame_pkg::*;

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic mem_addr_type blk_addr(input logic [4:0] blk, input logic [3:0] pos);
    return {blk, pos};
  endfunction : blk_addr

  function automatic logic [15:0] crc_byte(input logic [15:0] c, input data_byte_type d);
    logic [15:0] r;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      r = (r[15] ^ d[i]) ? ({r[14:0], 1'b0} ^ `CRC_POLY) : {r[14:0], 1'b0};
    end
    return r;
  endfunction : crc_byte

  function automatic logic sc_match(input logic [15:0] req, input logic [15:0] st);
    if (req == `SC_WILDCARD) begin
      return 1'b1;
    end else if (req == `SC_UPPER_WILD) begin
      return st[15:8] == `SC_UPPER_BYTE;
    end
    return req == st;
  endfunction : sc_match

  function automatic data_byte_type param_default(input logic [3:0] k);
    unique case (k)
      4'h0:    return `DEF_SC_HI;
      4'h1:    return `DEF_SC_LO;
      4'h2:    return `DEF_IDM_0;
      4'h3:    return `DEF_IDM_1;
      4'hA:    return `DEF_RT_PARAM;
      4'hB:    return `DEF_RT_PARAM;
      default: return `DEF_IDM_REST;
    endcase
  endfunction : param_default

  // ************************************************************
  // Power-up capture of the system area
  // ************************************************************
  logic [2:0]              valid_sync;
  logic                    sys_valid;
  logic [1:0]              settle;
  logic                    loading;
  logic                    loaded;
  logic                    ld_pend;
  logic [3:0]              ld_idx;
  logic [3:0]              ld_cap_idx;
  logic [11:0][7:0]        sys_param;
  logic                    bus_mem_wr;
  logic                    bus_mem_rd;
  logic                    ld_issue;
  data_byte_type           mem_q;
  logic [15:0]             stored_system_code;

  assign stored_system_code = {sys_param[0], sys_param[1]};

  // The strap passes three stages; only a value that stages two and three agree on is taken.
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      valid_sync <= 3'h0;
      sys_valid  <= 1'b0;
    end else begin
      valid_sync <= {valid_sync[1:0], i_sys_area_valid};
      if (valid_sync[1] == valid_sync[2]) begin
        sys_valid <= valid_sync[2];
      end
    end
  end

  assign bus_mem_wr = i_wr && !i_addr[9];
  assign bus_mem_rd = i_rd && !i_addr[9];
  // The bus never waits, so the power-up load yields the memory port to it.
  assign ld_issue   = loading && !bus_mem_wr && !bus_mem_rd;

  // Parameters are captured once after reset, so rewrites only count after the next reset.
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      settle     <= 2'h0;
      loading    <= 1'b0;
      loaded     <= 1'b0;
      ld_pend    <= 1'b0;
      ld_idx     <= 4'h0;
      ld_cap_idx <= 4'h0;
      sys_param  <= '0;
    end else begin
      if (!loaded && !loading && settle != 2'h3) begin
        settle <= settle + 2'h1;
      end
      if (settle == 2'h2) begin
        loading <= 1'b1;
      end
      ld_pend <= ld_issue;
      if (ld_issue) begin
        ld_cap_idx <= ld_idx;
        if (ld_idx == 4'(`SYS_PARAM_COUNT - 1)) begin
          loading <= 1'b0;
        end else begin
          ld_idx <= ld_idx + 4'h1;
        end
      end
      if (ld_pend) begin
        sys_param[ld_cap_idx] <= sys_valid ? mem_q : param_default(ld_cap_idx);
        if (ld_cap_idx == 4'(`SYS_PARAM_COUNT - 1)) begin
          loaded <= 1'b1;
        end
      end
    end
  end

  tag_frame_mem u_mem (
    .i_ref_clk (i_ref_clk),
    .i_wr      (bus_mem_wr),
    .i_rd      (bus_mem_rd || ld_issue),
    .i_addr    (ld_issue ? blk_addr(`SYS_BLOCK, ld_idx) : i_addr[8:0]),
    .i_wdata   (i_wr_data),
    .o_rdata   (mem_q)
  );

  // ************************************************************
  // Register port
  // ************************************************************
  logic          rate_hi;
  logic          rx_en;
  logic          rd_sel_mem;
  data_byte_type reg_q;
  data_byte_type ok_count;
  data_byte_type err_count;
  tx_state_type  tx_state;

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rate_hi <= 1'b0;
      rx_en   <= 1'b1;
    end else if (i_wr && i_addr == `REG_CTRL) begin
      rate_hi <= i_wr_data[0];
      rx_en   <= i_wr_data[1];
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rd_sel_mem <= 1'b0;
      reg_q      <= 8'h00;
    end else if (i_rd) begin
      rd_sel_mem <= !i_addr[9];
      unique case (i_addr)
        `REG_CTRL:      reg_q <= {6'h00, rx_en, rate_hi};
        `REG_STATUS:    reg_q <= {5'h00, sys_valid, loaded, tx_state == T_SEND};
        `REG_OK_COUNT:  reg_q <= ok_count;
        `REG_ERR_COUNT: reg_q <= err_count;
        default:        reg_q <= 8'h00;
      endcase
    end
  end

  assign o_rd_data = rd_sel_mem ? mem_q : reg_q;

  // ************************************************************
  // Receive framer
  // ************************************************************
  rx_state_type  rx_state;
  logic [23:0]   hunt_sh;
  logic [2:0]    bit_cnt;
  data_byte_type rx_byte;
  data_byte_type next_byte;
  logic          take_bit;
  logic          byte_done;
  logic [7:0]    rx_rem;
  logic [7:0]    rx_pos;
  logic [7:0]    data_len;
  logic [15:0]   rx_crc;
  data_byte_type crc_hi;
  logic          crc_second;
  data_byte_type req_cmd;
  logic [15:0]   req_code;
  logic          frame_ok;
  logic          crc_err;
  logic          poll_hit;

  // Bits are ignored while answering, which keeps one answer per command.
  assign take_bit  = i_rx_bit_stb && rx_en && loaded && tx_state == T_IDLE;
  assign next_byte = {rx_byte[6:0], i_rx_bit};
  assign byte_done = take_bit && rx_state != R_HUNT && bit_cnt == 3'h7;

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rx_state   <= R_HUNT;
      hunt_sh    <= 24'h000000;
      bit_cnt    <= 3'h0;
      rx_byte    <= 8'h00;
      rx_rem     <= 8'h00;
      rx_pos     <= 8'h00;
      data_len   <= 8'h00;
      rx_crc     <= `CRC_INIT;
      crc_hi     <= 8'h00;
      crc_second <= 1'b0;
      req_cmd    <= 8'h00;
      req_code   <= 16'h0000;
      frame_ok   <= 1'b0;
      crc_err    <= 1'b0;
    end else begin
      frame_ok <= 1'b0;
      crc_err  <= 1'b0;
      if (take_bit) begin
        hunt_sh <= {hunt_sh[22:0], i_rx_bit};
        rx_byte <= next_byte;
        bit_cnt <= (rx_state == R_HUNT) ? 3'h0 : bit_cnt + 3'h1;
      end
      unique case (rx_state)
        R_HUNT: begin
          if (take_bit && {hunt_sh[22:0], i_rx_bit} == {8'h00, `SYNC_CODE}) begin
            rx_state <= R_LEN;
          end
        end
        R_LEN: begin
          if (byte_done) begin
            rx_crc     <= crc_byte(`CRC_INIT, next_byte);
            rx_rem     <= next_byte - 8'h01;
            data_len   <= next_byte - 8'h01;
            rx_pos     <= 8'h00;
            crc_second <= 1'b0;
            if (next_byte == 8'h00) begin
              rx_state <= R_HUNT;
            end else begin
              rx_state <= (next_byte == 8'h01) ? R_CRC : R_DATA;
            end
          end
        end
        R_DATA: begin
          if (byte_done) begin
            rx_crc <= crc_byte(rx_crc, next_byte);
            rx_pos <= rx_pos + 8'h01;
            rx_rem <= rx_rem - 8'h01;
            if (rx_pos == 8'h00) req_cmd <= next_byte;
            if (rx_pos == 8'h01) req_code[15:8] <= next_byte;
            if (rx_pos == 8'h02) req_code[7:0] <= next_byte;
            if (rx_rem == 8'h01) rx_state <= R_CRC;
          end
        end
        R_CRC: begin
          if (byte_done) begin
            crc_hi     <= next_byte;
            crc_second <= 1'b1;
            if (crc_second) begin
              rx_state <= R_HUNT;
              frame_ok <= {crc_hi, next_byte} == rx_crc;
              crc_err  <= {crc_hi, next_byte} != rx_crc;
            end
          end
        end
      endcase
    end
  end

  assign poll_hit = frame_ok && req_cmd == `CMD_POLL && data_len >= `POLL_MIN_DATA
                    && sc_match(req_code, stored_system_code);

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ok_count  <= 8'h00;
      err_count <= 8'h00;
    end else begin
      if (frame_ok) ok_count <= ok_count + 8'h01;
      if (crc_err) err_count <= err_count + 8'h01;
    end
  end

  // ************************************************************
  // Poll answer, serialiser and Manchester coder
  // ************************************************************
  logic [4:0]    tx_idx;
  logic [2:0]    tx_bit;
  logic          tx_half;
  logic [8:0]    half_cnt;
  logic [8:0]    half_len;
  logic [15:0]   tx_crc;
  data_byte_type cur_byte;
  logic          cur_bit;

  assign half_len = rate_hi ? 9'(`HALF_BIT_HI - 1) : 9'(`HALF_BIT_LO - 1);

  always_comb begin
    cur_byte = `RTD_FIXED_LO;
    if (tx_idx < `PREAMBLE_BYTES) begin
      cur_byte = 8'h00;
    end else if (tx_idx == 5'h06) begin
      cur_byte = 8'(`SYNC_CODE >> 8);
    end else if (tx_idx == 5'h07) begin
      cur_byte = 8'(`SYNC_CODE);
    end else if (tx_idx == 5'h08) begin
      cur_byte = `RSP_LEN;
    end else if (tx_idx == 5'h09) begin
      cur_byte = `RSP_POLL;
    end else if (tx_idx <= 5'h11) begin
      cur_byte = sys_param[4'(tx_idx - 5'h08)];
    end else if (tx_idx == 5'h12 || tx_idx == 5'h13 || tx_idx == 5'h19) begin
      cur_byte = `RTD_FIXED_HI;
    end else if (tx_idx == 5'h17) begin
      cur_byte = sys_param[`IDX_RT_READ];
    end else if (tx_idx == 5'h18) begin
      cur_byte = sys_param[`IDX_RT_WRITE];
    end else if (tx_idx == 5'h1a) begin
      cur_byte = tx_crc[15:8];
    end else if (tx_idx == 5'h1b) begin
      cur_byte = tx_crc[7:0];
    end
  end

  assign cur_bit = cur_byte[3'h7 - tx_bit];

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      tx_state <= T_IDLE;
      tx_idx   <= 5'h00;
      tx_bit   <= 3'h0;
      tx_half  <= 1'b0;
      half_cnt <= 9'h000;
      tx_crc   <= `CRC_INIT;
    end else begin
      unique case (tx_state)
        T_IDLE: begin
          if (poll_hit) begin
            tx_state <= T_SEND;
            tx_idx   <= 5'h00;
            tx_bit   <= 3'h0;
            tx_half  <= 1'b0;
            half_cnt <= half_len;
            tx_crc   <= `CRC_INIT;
          end
        end
        T_SEND: begin
          if (half_cnt != 9'h000) begin
            half_cnt <= half_cnt - 9'h001;
          end else begin
            half_cnt <= half_len;
            tx_half  <= !tx_half;
            if (tx_half) begin
              tx_bit <= tx_bit + 3'h1;
              if (tx_bit == 3'h7) begin
                tx_idx <= tx_idx + 5'h01;
                if (tx_idx >= 5'h08 && tx_idx <= 5'h19) begin
                  tx_crc <= crc_byte(tx_crc, cur_byte);
                end
                if (tx_idx == `TX_LAST_IDX) begin
                  tx_state <= T_IDLE;
                end
              end
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_load_mod  <= 1'b0;
      o_tx_active <= 1'b0;
    end else begin
      o_tx_active <= tx_state == T_SEND;
      o_load_mod  <= (tx_state == T_SEND) && (tx_half ? !cur_bit : cur_bit);
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  a_answer_needs_poll: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    $rose(tx_state == T_SEND) |-> $past(poll_hit))
    else $error("answer started without an accepted poll");
  a_bad_crc_silent: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    crc_err |=> tx_state == T_IDLE [*3])
    else $error("answer sent for a frame with a bad check code");
  a_wildcard_answer: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    (frame_ok && req_cmd == 8'h00 && data_len >= 8'h03 && req_code == 16'hffff)
    |=> tx_state == T_SEND)
    else $error("wildcard poll not answered");
  a_upper_wild: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    (frame_ok && req_cmd == 8'h00 && data_len >= 8'h03 && req_code == 16'haaff
     && sys_param[0] == 8'haa) |=> tx_state == T_SEND)
    else $error("upper byte wildcard poll not answered");
  a_mismatch_silent: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    (frame_ok && req_code != 16'hffff && req_code != 16'haaff
     && req_code != stored_system_code) |=> tx_state == T_IDLE)
    else $error("poll answered on a mismatching code");
  a_preamble_zero: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    (tx_state == T_SEND && tx_idx < 5'h06 && !tx_half) |=> !o_load_mod)
    else $error("preamble byte not zero");
  a_rtd_fixed: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    (tx_state == T_SEND && !tx_half
     && (tx_idx == 5'h12 || tx_idx == 5'h13 || tx_idx == 5'h19)) |=> o_load_mod)
    else $error("fixed descriptor byte is not FF");
  a_half_timing: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    (tx_state == T_SEND && $changed(tx_half)) |-> $past(half_cnt) == 9'h000)
    else $error("half bit ended early");
  a_default_code: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    ($rose(loaded) && !sys_valid && $stable(sys_valid))
    |-> stored_system_code == 16'haaff && sys_param[`IDX_RT_READ] == 8'hff)
    else $error("system code default not applied");

  c_poll_answered: cover property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    poll_hit ##1 tx_state == T_SEND);
  c_crc_reject:    cover property (@(posedge i_ref_clk) disable iff (!i_rst_b) crc_err);
  c_answer_done:   cover property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    $fell(o_tx_active));

endmodule : contactless_tag_frame_handler

`default_nettype wire

// ---- reader_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****
// Reader side: frames commands into pre-decoded bits.
// ****
module reader_model (
  input  wire logic i_ref_clk,
  output logic      o_bit,
  output logic      o_stb
);
  initial begin
    o_bit = 1'b0;
    o_stb = 1'b0;
  end

  function automatic logic [15:0] crc16(input logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'h0000;
    foreach (q[i]) begin
      c = c ^ {q[i], 8'h00};
      for (int b = 0; b < 8; b++) begin
        c = c[15] ? ((c << 1) ^ 16'h1021) : (c << 1);
      end
    end
    return c;
  endfunction : crc16

  task automatic send(input logic [7:0] d[$], input logic bad);
    logic [7:0]  f[$];
    logic [15:0] c;
    f = {8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hb2, 8'h4d};
    d.push_front(8'(d.size() + 1));
    c = crc16(d) ^ {15'h0000, bad};
    f = {f, d, c[15:8], c[7:0]};
    foreach (f[i]) begin
      for (int b = 7; b >= 0; b--) begin
        @(posedge i_ref_clk);
        o_bit <= f[i][b];
        o_stb <= 1'b1;
        @(posedge i_ref_clk);
        o_stb <= 1'b0;
        // The line shows the inverse between strobes so a stale bit is never reused.
        o_bit <= ~f[i][b];
      end
    end
  endtask : send
endmodule : reader_model
`default_nettype wire

// ---- testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "tag_frame_regs.svh"
module testbench;
  import tag_frame_pkg::*;
  typedef struct packed {logic v; logic [15:0] code; logic hit;} row_type;
  logic          i_ref_clk, i_rst_b, i_wr, i_rd, i_sys_area_valid;
  logic          rx_bit, rx_stb, o_load_mod, o_tx_active;
  bus_addr_type  i_addr;
  data_byte_type i_wr_data, o_rd_data, rv;
  data_byte_type rsp[28];
  logic [7:0]    ex[$];
  logic [15:0]   c;
  int            fails = 0;
  int            cmp_count = 0;
  row_type rows[8] = '{'{1'b0, 16'hffff, 1'b1}, '{1'b0, 16'haaff, 1'b1},
    '{1'b0, 16'haaf0, 1'b0}, '{1'b0, 16'h1234, 1'b0}, '{1'b1, 16'h1234, 1'b1},
    '{1'b1, 16'hffff, 1'b1}, '{1'b1, 16'haaff, 1'b0}, '{1'b1, 16'h1235, 1'b0}};

  contactless_tag_frame_handler i_dut (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b),
    .i_addr(i_addr), .i_wr_data(i_wr_data), .i_wr(i_wr), .i_rd(i_rd),
    .o_rd_data(o_rd_data), .i_sys_area_valid(i_sys_area_valid), .i_rx_bit(rx_bit),
    .i_rx_bit_stb(rx_stb), .o_load_mod(o_load_mod), .o_tx_active(o_tx_active));
  reader_model i_reader (.i_ref_clk(i_ref_clk), .o_bit(rx_bit), .o_stb(rx_stb));

  initial begin
    i_ref_clk = 1'b0;
    forever #2.5 i_ref_clk = ~i_ref_clk;
  end

  // ****
  // Shared tasks.
  // ****
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim

  task automatic wr(input bus_addr_type a, input data_byte_type d);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_wr_data <= d;
    i_wr <= 1'b1;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
  endtask : wr

  task automatic rd(input bus_addr_type a, output data_byte_type d);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1 d = o_rd_data;
  endtask : rd

  task automatic do_reset(input logic v);
    @(posedge i_ref_clk);
    i_rst_b <= 1'b0;
    i_sys_area_valid <= v;
    repeat (16) @(posedge i_ref_clk);
    i_rst_b <= 1'b1;
    // Power-up load of the system area takes about 16 edges.
    repeat (30) @(posedge i_ref_clk);
  endtask : do_reset

  // Sends a command and reports whether a response frame started.
  task automatic cmd(input logic [7:0] op, input logic [15:0] code, input logic bad,
                     output logic hit);
    i_reader.send('{op, code[15:8], code[7:0]}, bad);
    hit = 1'b0;
    repeat (40) begin
      @(posedge i_ref_clk);
      if (o_tx_active === 1'b1) hit = 1'b1;
    end
  endtask : cmd

  logic hit;
  initial begin
    i_rst_b = 1'b0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = '0;
    i_wr_data = '0;
    i_sys_area_valid = 1'b0;
    do_reset(1'b0);
    wr(10'h1f5, 8'h3c);
    rd(10'h1f5, rv);
    chk(rv, 8'h3c);
    rd(10'h204, rv);
    chk(rv, 8'h00);
    // System area: code 12 34, identifier 11..18, time parameters 5a a5.
    ex = {8'h12, 8'h34, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17, 8'h18,
          8'h5a, 8'ha5};
    foreach (ex[i]) wr(10'h1e0 + 10'(i), ex[i]);
    $display("test memory done");
    foreach (rows[i]) begin
      do_reset(rows[i].v);
      cmd(`CMD_POLL, rows[i].code, 1'b0, hit);
      chk(hit, rows[i].hit);
    end
    $display("test poll table done");
    do_reset(1'b1);
    wr(10'h1ea, 8'h77);
    rd(`REG_STATUS, rv);
    chk(rv, 8'h06);
    wr(`REG_CTRL, 8'h01);
    cmd(`CMD_POLL, 16'hffff, 1'b0, hit);
    chk(hit, 1'b0);
    rd(`REG_OK_COUNT, rv);
    chk(rv, 8'h00);
    wr(`REG_CTRL, 8'h03);
    rd(`REG_CTRL, rv);
    chk(rv, 8'h03);
    cmd(`CMD_POLL, 16'h1234, 1'b1, hit);
    chk(hit, 1'b0);
    rd(`REG_ERR_COUNT, rv);
    chk(rv, 8'h01);
    cmd(8'h06, 16'h1234, 1'b0, hit);
    chk(hit, 1'b0);
    rd(`REG_OK_COUNT, rv);
    chk(rv, 8'h01);
    $display("test crc done");
    i_reader.send('{`CMD_POLL, 8'h12, 8'h34}, 1'b0);
    repeat (40) if (o_tx_active !== 1'b1) @(posedge i_ref_clk);
    repeat (600) if (o_load_mod !== 1'b1) @(posedge i_ref_clk);
    rsp[0] = 8'h00;
    repeat (`HALF_BIT_HI + `HALF_BIT_HI / 2) @(posedge i_ref_clk);
    for (int k = 1; k < 224; k++) begin
      rsp[k / 8][7 - k % 8] = o_load_mod;
      repeat (2 * `HALF_BIT_HI) @(posedge i_ref_clk);
    end
    ex = {8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hb2, 8'h4d, 8'h12, 8'h01,
          8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17, 8'h18,
          8'hff, 8'hff, 8'h00, 8'h00, 8'h00, 8'h5a, 8'ha5, 8'hff};
    c = i_reader.crc16(ex[8:25]);
    ex = {ex, c[15:8], c[7:0]};
    for (int i = 0; i < 10; i++) chk(rsp[i], ex[i]);
    for (int i = 10; i < 18; i++) chk(rsp[i], ex[i]);
    for (int i = 18; i < 26; i++) chk(rsp[i], ex[i]);
    for (int i = 26; i < 28; i++) chk(rsp[i], ex[i]);
    $display("test response frame done");
    end_sim();
  end

  initial begin
    #2000000;
    fails++;
    $display("Error at %0t: watchdog expired", $time);
    end_sim();
  end
endmodule : testbench
`default_nettype wire
